/* File: design/ira_pages.sv */
/*
 * Indirect page store: page-zero pattern and timing bytes, per-channel
 * and shared test pages, transmitter test page, with a read mux.
 * Assumes the window front end gives one write strobe per data write.
 */
`timescale 1ns/1ps
module ira_pages (
	// Clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// Window access
	input wire logic wr_i,
	input wire logic [3:0] page_i,
	input wire logic [7:0] ofs_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	// Pattern generator controls
	output logic pattern_on_o,
	output logic fixed_colour_select_o,
	output logic [1:0] bar_count_code_o,
	output logic [3:0] bar_total_o,
	output logic [3:0] block_size_o,
	output logic [1:0] pattern_virtual_channel_o,
	output logic [5:0] pattern_data_type_o,
	output logic [15:0] pattern_line_length_o
);
	import ira_pkg::*;

	typedef struct packed {
		logic [PGEN_N-1:0][7:0] pgen;
		logic [TIM_N-1:0][7:0] tim;
		logic [CH_N-1:0][7:0] ch0;
		logic [CH_N-1:0][7:0] ch1;
		logic [SHR_N-1:0][7:0] shr;
		logic [CSI_N-1:0][7:0] csi;
		logic [3:0] bars;
	} ira_pages_t;

	ira_pages_t st;
	ira_pages_t next_st;
	logic in_pgen;
	logic in_tim;
	logic in_ch;
	logic in_shr;
	logic in_csi;
	logic [4:0] pg_idx;
	logic [3:0] tim_idx;
	logic [4:0] lo_idx;

	// Range decode; offsets outside every range hit nothing
	assign in_pgen = ofs_i >= PGEN_FIRST && ofs_i <= PGEN_LAST;
	assign in_tim = ofs_i >= TIM_FIRST && ofs_i <= TIM_LAST;
	assign in_ch = ofs_i <= CH_LAST;
	assign in_shr = ofs_i <= SHR_LAST;
	assign in_csi = ofs_i <= CSI_LAST;
	assign pg_idx = 5'(ofs_i - PGEN_FIRST);
	assign tim_idx = 4'(ofs_i - TIM_FIRST);
	assign lo_idx = ofs_i[4:0];

	// Read mux; reserved pages and holes read zero
	always_comb begin
		rdata_o = READ_ZERO;
		case (page_i)
		PAGE_PGEN: begin
			if (in_pgen)
				rdata_o = st.pgen[pg_idx];
			else if (in_tim)
				rdata_o = st.tim[tim_idx];
		end
		PAGE_CH0, PAGE_ALL: begin
			if (in_ch)
				rdata_o = st.ch0[lo_idx];
		end
		PAGE_CH1: begin
			if (in_ch)
				rdata_o = st.ch1[lo_idx];
		end
		PAGE_SHARE: begin
			if (in_shr)
				rdata_o = st.shr[lo_idx];
		end
		PAGE_CSI: begin
			if (in_csi)
				rdata_o = st.csi[lo_idx];
		end
		default: rdata_o = READ_ZERO;
		endcase
	end

	// Write decode; broadcast page lands in both channel sets
	always_comb begin
		next_st = st;
		if (wr_i) begin
			case (page_i)
			PAGE_PGEN: begin
				if (in_pgen)
					next_st.pgen[pg_idx] = wdata_i;
				else if (in_tim)
					next_st.tim[tim_idx] = wdata_i;
			end
			PAGE_CH0: begin
				if (in_ch)
					next_st.ch0[lo_idx] = wdata_i;
			end
			PAGE_CH1: begin
				if (in_ch)
					next_st.ch1[lo_idx] = wdata_i;
			end
			PAGE_ALL: begin
				if (in_ch) begin
					next_st.ch0[lo_idx] = wdata_i;
					next_st.ch1[lo_idx] = wdata_i;
				end
			end
			PAGE_SHARE: begin
				if (in_shr)
					next_st.shr[lo_idx] = wdata_i;
			end
			PAGE_CSI: begin
				if (in_csi)
					next_st.csi[lo_idx] = wdata_i;
			end
			default: next_st = st;
			endcase
		end
		// Decoded bar total kept as a flop so the output is glitch free
		next_st.bars = BARS_ONE <<
			next_st.pgen[PGI_CFG][PG_BARS_MSB:PG_BARS_LSB];
	end

	// State register with documented page-zero defaults
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			st <= '0;
			st.pgen[PGI_CTL] <= PG_CTL_RESET;
			st.pgen[PGI_CFG] <= PG_CFG_RESET;
			st.pgen[PGI_DI] <= PG_DI_RESET;
			st.pgen[PGI_HI] <= PG_HI_RESET;
			st.pgen[PGI_LO] <= PG_LO_RESET;
			st.bars <= BARS_RESET;
		end else begin
			st <= next_st;
		end
	end

	// Pattern controls straight from the stored bytes
	assign pattern_on_o = st.pgen[PGI_CTL][PG_ON_BIT];
	assign fixed_colour_select_o = st.pgen[PGI_CFG][PG_FIXED_BIT];
	assign bar_count_code_o = st.pgen[PGI_CFG][PG_BARS_MSB:PG_BARS_LSB];
	assign bar_total_o = st.bars;
	assign block_size_o = st.pgen[PGI_CFG][PG_SIZE_MSB:PG_SIZE_LSB];
	assign pattern_virtual_channel_o =
		st.pgen[PGI_DI][PG_VC_MSB:PG_VC_LSB];
	assign pattern_data_type_o = st.pgen[PGI_DI][PG_DT_MSB:PG_DT_LSB];
	assign pattern_line_length_o =
		{st.pgen[PGI_HI], st.pgen[PGI_LO]};

endmodule : ira_pages

/* File: design/ira_pkg.sv */
/*
 * Shared constants for the indirect register access block: main-space
 * offsets, control fields, page codes, page-zero layout and reset values.
 * Assumes an 8-bit register space reached by decoded serial transactions.
 */
package ira_pkg;

	// Main-space register offsets
	localparam logic [7:0] REG_IND_CTL = 8'hb0;
	localparam logic [7:0] REG_IND_OFS = 8'hb1;
	localparam logic [7:0] REG_IND_DATA = 8'hb2;
	localparam logic [7:0] REG_ALIAS = 8'hf9;
	localparam logic [7:0] REG_RSVD_FA = 8'hfa;
	localparam logic [7:0] REG_RSVD_FB = 8'hfb;

	// Field positions in the control and alias registers
	localparam int CTL_PAGE_LSB = 2;
	localparam int CTL_PAGE_MSB = 5;
	localparam int CTL_AUTOINC_BIT = 1;
	localparam int ALIAS_LSB = 1;
	localparam int ALIAS_MSB = 7;

	// Reset values of the main-space registers, plus the alias-off, read-zero and step constants
	localparam logic [7:0] CTL_RESET = 8'h00;
	localparam logic [7:0] OFS_RESET = 8'h00;
	localparam logic [7:0] ALIAS_RESET = 8'h00;
	localparam logic [6:0] ALIAS_OFF = 7'h00;
	localparam logic [7:0] READ_ZERO = 8'h00;
	localparam logic [7:0] OFS_STEP = 8'h01;

	// Page select codes
	localparam logic [3:0] PAGE_PGEN = 4'h0;
	localparam logic [3:0] PAGE_CH0 = 4'h1;
	localparam logic [3:0] PAGE_CH1 = 4'h2;
	localparam logic [3:0] PAGE_RSVD3 = 4'h3;
	localparam logic [3:0] PAGE_SHARE = 4'h5;
	localparam logic [3:0] PAGE_ALL = 4'h6;
	localparam logic [3:0] PAGE_CSI = 4'h7;

	// Offset ranges inside the pages
	localparam logic [7:0] PGEN_FIRST = 8'h01;
	localparam logic [7:0] PGEN_LAST = 8'h1f;
	localparam logic [7:0] TIM_FIRST = 8'h40;
	localparam logic [7:0] TIM_LAST = 8'h48;
	localparam logic [7:0] CH_LAST = 8'h14;
	localparam logic [7:0] SHR_LAST = 8'h04;
	localparam logic [7:0] CSI_LAST = 8'h1d;
	localparam int PGEN_N = 31;
	localparam int TIM_N = 9;
	localparam int CH_N = 21;
	localparam int SHR_N = 5;
	localparam int CSI_N = 30;

	// Page-zero pattern registers: offsets and array indices
	localparam logic [7:0] PG_CTL = 8'h01;
	localparam logic [4:0] PGI_CTL = 5'h00;
	localparam logic [4:0] PGI_CFG = 5'h01;
	localparam logic [4:0] PGI_DI = 5'h02;
	localparam logic [4:0] PGI_HI = 5'h03;
	localparam logic [4:0] PGI_LO = 5'h04;

	// Page-zero reset values: bars 8, block 3, RGB888, 1920 bytes
	localparam logic [7:0] PG_CTL_RESET = 8'h00;
	localparam logic [7:0] PG_CFG_RESET = 8'h33;
	localparam logic [7:0] PG_DI_RESET = 8'h24;
	localparam logic [7:0] PG_HI_RESET = 8'h07;
	localparam logic [7:0] PG_LO_RESET = 8'h80;
	localparam logic [3:0] BARS_RESET = 4'h8;
	localparam logic [3:0] BARS_ONE = 4'h1;

	// Page-zero field positions
	localparam int PG_ON_BIT = 0;
	localparam int PG_FIXED_BIT = 7;
	localparam int PG_BARS_MSB = 5;
	localparam int PG_BARS_LSB = 4;
	localparam int PG_SIZE_MSB = 3;
	localparam int PG_SIZE_LSB = 0;
	localparam int PG_VC_MSB = 7;
	localparam int PG_VC_LSB = 6;
	localparam int PG_DT_MSB = 5;
	localparam int PG_DT_LSB = 0;

endpackage : ira_pkg

/* File: design/ira_top.sv */
/*
 * Register access front end: main and port-one alias target decode,
 * indirect window (control, offset, data) with auto-increment, and the
 * paged store holding the pattern generator controls.
 * Assumes the serial target logic outside hands over one decoded
 * transaction per cycle at most: target, direction, offset and data.
 */
// How it works
// - Alias target bits 7:1 claim port-one transactions
// - Zero alias field disables the alias decoder
// - Alias transactions also reach all shared registers
// - Window registers sit at three consecutive offsets
// - Control bits 5:2 choose the indirect page
// - Auto-increment advances offset after each data access
// - Page zero: pattern and timing ranges
// - Pages one, two: channel test sets
// - Page seven transmitter test; three, four reserved
// - Page-zero 0x01 bit 0 enables generator
// - Config bit 7 picks fixed or bars
// - Fixed block size field, reset three
// - Virtual channel from 0x03 bits 7:6
// - Data type bits 5:0, reset 0x24
// - 0x04 holds line length high byte
// - 0x05 holds line length low byte
`timescale 1ns/1ps
module ira_top #(
	// Main target address; value is arbitrary
	parameter logic [6:0] MAIN_TARGET = 7'h30
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// Decoded transaction in
	input wire logic xact_valid_i,
	input wire logic [6:0] xact_target_i,
	input wire logic xact_write_i,
	input wire logic [7:0] xact_reg_i,
	input wire logic [7:0] xact_wdata_i,
	// Transaction answer
	output logic xact_done_o,
	output logic xact_claimed_o,
	output logic xact_port_one_o,
	output logic [7:0] xact_rdata_o,
	// Pattern generator controls
	output logic pattern_on_o,
	output logic fixed_colour_select_o,
	output logic [1:0] bar_count_code_o,
	output logic [3:0] bar_total_o,
	output logic [3:0] block_size_o,
	output logic [1:0] pattern_virtual_channel_o,
	output logic [5:0] pattern_data_type_o,
	output logic [15:0] pattern_line_length_o
);
	import ira_pkg::*;

	typedef struct packed {
		logic [7:0] ctl;
		logic [7:0] ofs;
		logic [7:0] alias_reg;
		logic done;
		logic claimed;
		logic port_one;
		logic [7:0] rdata;
	} ira_state_t;

	ira_state_t st;
	ira_state_t next_st;
	logic hit_main;
	logic hit_alias;
	logic claim_now;
	logic pg_wr;
	logic [7:0] pg_rdata;
	logic [3:0] page_sel;
	logic [6:0] port_one_alias_value;

	// Target decode; a zero alias never matches
	assign port_one_alias_value = st.alias_reg[ALIAS_MSB:ALIAS_LSB];
	assign hit_main = xact_target_i == MAIN_TARGET;
	assign hit_alias = port_one_alias_value != ALIAS_OFF &&
		xact_target_i == port_one_alias_value;
	assign claim_now = xact_valid_i && (hit_main || hit_alias);
	assign page_sel = st.ctl[CTL_PAGE_MSB:CTL_PAGE_LSB];

	// Transaction handling; window is shared so the alias reaches it too
	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		next_st.claimed = 1'b0;
		next_st.port_one = 1'b0;
		pg_wr = 1'b0;
		if (xact_valid_i) begin
			next_st.done = 1'b1;
			next_st.rdata = READ_ZERO;
		end
		if (claim_now) begin
			next_st.claimed = 1'b1;
			next_st.port_one = hit_alias;
			case (xact_reg_i)
			REG_IND_CTL: begin
				if (xact_write_i)
					next_st.ctl = xact_wdata_i;
				else
					next_st.rdata = st.ctl;
			end
			REG_IND_OFS: begin
				if (xact_write_i)
					next_st.ofs = xact_wdata_i;
				else
					next_st.rdata = st.ofs;
			end
			REG_IND_DATA: begin
				if (xact_write_i)
					pg_wr = 1'b1;
				else
					next_st.rdata = pg_rdata;
				// Offset wraps at 0xff; holes still step
				if (st.ctl[CTL_AUTOINC_BIT])
					next_st.ofs = st.ofs + OFS_STEP;
			end
			REG_ALIAS: begin
				// Bit 0 is read-only zero
				if (xact_write_i)
					next_st.alias_reg = {xact_wdata_i[ALIAS_MSB:ALIAS_LSB],
						1'b0};
				else
					next_st.rdata = st.alias_reg;
			end
			REG_RSVD_FA, REG_RSVD_FB: next_st.rdata = READ_ZERO;
			default: next_st.rdata = READ_ZERO;
			endcase
		end
	end

	// State register
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			st <= '0;
			st.ctl <= CTL_RESET;
			st.ofs <= OFS_RESET;
			st.alias_reg <= ALIAS_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign xact_done_o = st.done;
	assign xact_claimed_o = st.claimed;
	assign xact_port_one_o = st.port_one;
	assign xact_rdata_o = st.rdata;

	// Paged store behind the data register
	ira_pages u_pages (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.wr_i(pg_wr),
		.page_i(page_sel),
		.ofs_i(st.ofs),
		.wdata_i(xact_wdata_i),
		.rdata_o(pg_rdata),
		.pattern_on_o(pattern_on_o),
		.fixed_colour_select_o(fixed_colour_select_o),
		.bar_count_code_o(bar_count_code_o),
		.bar_total_o(bar_total_o),
		.block_size_o(block_size_o),
		.pattern_virtual_channel_o(pattern_virtual_channel_o),
		.pattern_data_type_o(pattern_data_type_o),
		.pattern_line_length_o(pattern_line_length_o)
	);

	// Checks on the window and decode
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);

	// Offsets of the pattern shape and packet identity bytes
	localparam logic [7:0] PG_CFG_OFS = PG_CTL + OFS_STEP;
	localparam logic [7:0] PG_DI_OFS = PG_CFG_OFS + OFS_STEP;

	sequence s_data_access;
		claim_now && xact_reg_i == REG_IND_DATA;
	endsequence

	sequence s_enable_write;
		s_data_access ##0 xact_write_i && page_sel == PAGE_PGEN &&
			st.ofs == PG_CTL;
	endsequence

	sequence s_hole_read;
		s_data_access ##0 !xact_write_i && page_sel == PAGE_RSVD3;
	endsequence

	sequence s_ctl_write;
		claim_now && xact_write_i && xact_reg_i == REG_IND_CTL;
	endsequence

	sequence s_ctl_read;
		claim_now && !xact_write_i && xact_reg_i == REG_IND_CTL;
	endsequence

	sequence s_cfg_write;
		s_data_access ##0 xact_write_i && page_sel == PAGE_PGEN &&
			st.ofs == PG_CFG_OFS;
	endsequence

	sequence s_ident_write;
		s_data_access ##0 xact_write_i && page_sel == PAGE_PGEN &&
			st.ofs == PG_DI_OFS;
	endsequence

	alias_claim_a: assert property (
		xact_valid_i && port_one_alias_value != ALIAS_OFF &&
		xact_target_i == port_one_alias_value
		|=> xact_claimed_o && xact_port_one_o)
		else $error("alias target not claimed as port one");

	alias_off_a: assert property (
		xact_valid_i && port_one_alias_value == ALIAS_OFF &&
		xact_target_i != MAIN_TARGET
		|=> xact_done_o && !xact_claimed_o)
		else $error("disabled alias still claimed");

	alias_shared_a: assert property (
		claim_now && hit_alias && xact_write_i &&
		xact_reg_i == REG_IND_OFS
		|=> st.ofs == $past(xact_wdata_i))
		else $error("shared window not reached via alias");

	// Host leaves one idle cycle between transfers
	ctl_readback_a: assert property (
		s_ctl_write ##1 !xact_valid_i ##1 s_ctl_read
		|=> xact_rdata_o == $past(xact_wdata_i, 3))
		else $error("control register readback wrong");

	page_field_a: assert property (
		claim_now && xact_write_i && xact_reg_i == REG_IND_CTL
		|=> page_sel == $past(xact_wdata_i[CTL_PAGE_MSB:CTL_PAGE_LSB]))
		else $error("page select not taken from bits 5:2");

	auto_step_a: assert property (
		s_data_access ##0 st.ctl[CTL_AUTOINC_BIT]
		|=> st.ofs == $past(st.ofs) + OFS_STEP)
		else $error("offset did not advance");

	no_step_a: assert property (
		s_data_access ##0 !st.ctl[CTL_AUTOINC_BIT]
		|=> $stable(st.ofs))
		else $error("offset moved without auto-increment");

	enable_write_a: assert property (
		s_enable_write
		|=> pattern_on_o == $past(xact_wdata_i[PG_ON_BIT]))
		else $error("generator enable not written");

	hole_read_a: assert property (
		s_hole_read |=> xact_done_o && xact_rdata_o == READ_ZERO)
		else $error("reserved page read not zero");

	hole_write_a: assert property (
		s_data_access ##0 xact_write_i && page_sel == PAGE_RSVD3
		|=> $stable(pattern_line_length_o) && $stable(pattern_on_o))
		else $error("reserved page write changed state");

	bar_decode_a: assert property (
		bar_total_o == (BARS_ONE << bar_count_code_o))
		else $error("bar total does not match code");

	// Refused and quiet cases, alias register and page-zero fields
	unclaimed_quiet_a: assert property (
		xact_valid_i && !claim_now
		|=> !xact_claimed_o && !xact_port_one_o &&
			xact_rdata_o == READ_ZERO && $stable(st.ctl) && $stable(st.ofs))
		else $error("unclaimed transaction changed state");

	port_one_main_a: assert property (
		claim_now && !hit_alias |=> xact_claimed_o && !xact_port_one_o)
		else $error("main target flagged as port one");

	alias_write_a: assert property (
		claim_now && xact_write_i && xact_reg_i == REG_ALIAS
		|=> port_one_alias_value ==
			$past(xact_wdata_i[ALIAS_MSB:ALIAS_LSB]) &&
			!st.alias_reg[ALIAS_LSB-1])
		else $error("alias field not stored from bits 7:1");

	ofs_write_a: assert property (
		claim_now && xact_write_i && xact_reg_i == REG_IND_OFS
		|=> st.ofs == $past(xact_wdata_i))
		else $error("offset register not written");

	data_read_a: assert property (
		s_data_access ##0 !xact_write_i && page_sel == PAGE_PGEN &&
		st.ofs == PG_CTL
		|=> xact_rdata_o[PG_ON_BIT] == pattern_on_o)
		else $error("window read does not return enable byte");

	cfg_write_a: assert property (
		s_cfg_write
		|=> fixed_colour_select_o ==
			$past(xact_wdata_i[PG_FIXED_BIT]) &&
			block_size_o ==
			$past(xact_wdata_i[PG_SIZE_MSB:PG_SIZE_LSB]))
		else $error("pattern shape byte not applied");

	ident_write_a: assert property (
		s_ident_write
		|=> pattern_virtual_channel_o ==
			$past(xact_wdata_i[PG_VC_MSB:PG_VC_LSB]) &&
			pattern_data_type_o ==
			$past(xact_wdata_i[PG_DT_MSB:PG_DT_LSB]))
		else $error("packet identity byte not applied");

	// Answer is a one-cycle pulse; read data holds in between
	rdata_hold_a: assert property (
		!xact_valid_i |=> $stable(xact_rdata_o) && !xact_done_o)
		else $error("read data moved without a transaction");

endmodule : ira_top

/* File: dv/ira_host.sv */
/*
 * Host model: issues decoded register transactions one at a time and
 * runs the indirect window write and read sequences.
 * Assumes the block answers on the edge after each taken request.
 */
`timescale 1ns/1ps
module ira_host #(
	parameter logic [6:0] MAIN = 7'h30
) (
	// Clock
	input wire logic clock_i,
	// Request out
	output logic xact_valid_o,
	output logic [6:0] xact_target_o,
	output logic xact_write_o,
	output logic [7:0] xact_reg_o,
	output logic [7:0] xact_wdata_o,
	// Answer in
	input wire logic xact_done_i,
	input wire logic xact_claimed_i,
	input wire logic xact_port_one_i,
	input wire logic [7:0] xact_rdata_i
);
	import ira_pkg::*;
	logic done;
	logic claimed;
	logic port_one;
	logic [7:0] rdata;
	logic [6:0] tgt;

	// Idle lines at time zero
	initial begin
		xact_valid_o = 1'b0;
		xact_target_o = 7'h00;
		xact_write_o = 1'b0;
		xact_reg_o = 8'h00;
		xact_wdata_o = 8'h00;
		tgt = MAIN;
	end

	// One transfer; released lines are inverted so stale values never match
	task automatic xfer(input logic w, input logic [7:0] r,
		input logic [7:0] d);
		@(posedge clock_i);
		xact_valid_o <= 1'b1;
		xact_target_o <= tgt;
		xact_write_o <= w;
		xact_reg_o <= r;
		xact_wdata_o <= d;
		@(posedge clock_i);
		xact_valid_o <= 1'b0;
		xact_target_o <= ~tgt;
		xact_write_o <= ~w;
		xact_reg_o <= ~r;
		xact_wdata_o <= ~d;
		#1;
		done = xact_done_i;
		claimed = xact_claimed_i;
		port_one = xact_port_one_i;
		rdata = xact_rdata_i;
	endtask : xfer

	// Window write: control, then offset, then data
	task automatic ind_wr(input logic [3:0] pg, input logic ai,
		input logic [7:0] o, input logic [7:0] d);
		xfer(1'b1, REG_IND_CTL, {2'b00, pg, ai, 1'b0});
		xfer(1'b1, REG_IND_OFS, o);
		xfer(1'b1, REG_IND_DATA, d);
	endtask : ind_wr

	// Window read: control, then offset, then data read
	task automatic ind_rd(input logic [3:0] pg, input logic ai,
		input logic [7:0] o);
		xfer(1'b1, REG_IND_CTL, {2'b00, pg, ai, 1'b0});
		xfer(1'b1, REG_IND_OFS, o);
		xfer(1'b0, REG_IND_DATA, 8'h00);
	endtask : ind_rd
endmodule : ira_host

/* File: dv/tb.sv */
/*
 * Self-checking bench for the register access front end.
 * Assumes the host model drives all transaction inputs.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb;
	import ira_pkg::*;
	localparam logic [6:0] MAIN_T = 7'h30;
	logic clock_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic v, w, done, cl, p1, on, fx;
	logic [6:0] tg;
	logic [7:0] r, d, q;
	logic [1:0] bc, vc;
	logic [3:0] bt, bs;
	logic [5:0] dt;
	logic [15:0] ll;
	int error_cnt = 0;
	int checks = 0;
	logic [7:0] vals [5];
	logic [7:0] x;
	// Page, offset, implemented flag for each probe
	logic [3:0] pgs [10] = '{4'h0, 4'h0, 4'h0, 4'h1, 4'h2, 4'h5, 4'h7,
		4'h3, 4'h4, 4'h0};
	logic [7:0] ofs [10] = '{8'h1f, 8'h40, 8'h48, 8'h14, 8'h14, 8'h04,
		8'h1d, 8'h14, 8'h00, 8'h20};
	logic impl [10] = '{1, 1, 1, 1, 1, 1, 1, 0, 0, 0};

	// Free-running system clock
	always #2.5 clock_i = ~clock_i;

	ira_top #(.MAIN_TARGET(MAIN_T)) dut (.clock_i(clock_i),
		.sys_rst_i(sys_rst_i), .xact_valid_i(v), .xact_target_i(tg),
		.xact_write_i(w), .xact_reg_i(r), .xact_wdata_i(d),
		.xact_done_o(done), .xact_claimed_o(cl), .xact_port_one_o(p1),
		.xact_rdata_o(q), .pattern_on_o(on), .fixed_colour_select_o(fx),
		.bar_count_code_o(bc), .bar_total_o(bt), .block_size_o(bs),
		.pattern_virtual_channel_o(vc), .pattern_data_type_o(dt),
		.pattern_line_length_o(ll));

	ira_host #(.MAIN(MAIN_T)) host (.clock_i(clock_i), .xact_valid_o(v),
		.xact_target_o(tg), .xact_write_o(w), .xact_reg_o(r),
		.xact_wdata_o(d), .xact_done_i(done), .xact_claimed_i(cl),
		.xact_port_one_i(p1), .xact_rdata_i(q));

	function automatic logic [3:0] bars(input logic [1:0] c);
		return 4'h1 << c;
	endfunction : bars

	task automatic report_and_stop();
		if (error_cnt == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop

	// Main-space read with expected value
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		host.xfer(1'b0, a, 8'h00);
		`CHK({host.done, host.claimed}, 2'b11)
		`CHK(host.rdata, e)
	endtask : rd_chk

	// Hang guard
	initial begin
		repeat (20000) @(posedge clock_i);
		error_cnt++;
		report_and_stop();
	end

	initial begin
		void'($urandom(32'h1e22));
		repeat (8) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		#1;
		`CHK({on, fx, bc, bt, bs}, {2'b00, 2'h3, 4'h8, 4'h3})
		`CHK({vc, dt}, {2'h0, 6'h24})
		`CHK(ll, 16'h0780)
		rd_chk(REG_ALIAS, 8'h00);
		rd_chk(REG_RSVD_FA, 8'h00);
		rd_chk(REG_RSVD_FB, 8'h00);
		// Page-zero reset bytes 0x00..0x05 by auto-increment reads
		host.ind_rd(PAGE_PGEN, 1'b1, 8'h00);
		`CHK(host.rdata, 8'h00)
		vals = '{8'h00, 8'h33, 8'h24, 8'h07, 8'h80};
		for (int i = 1; i < 5; i++) begin
			host.xfer(1'b0, REG_IND_DATA, 8'h00);
			`CHK(host.rdata, vals[i-1])
		end
		host.xfer(1'b0, REG_IND_DATA, 8'h00);
		`CHK(host.rdata, 8'h80)
		// Random bursts; each round forces one bar code
		for (int k = 0; k < 4; k++) begin
			for (int i = 0; i < 5; i++) vals[i] = 8'($urandom);
			vals[1][5:4] = k[1:0];
			// Block size zero is not a legal host value
			if (vals[1][3:0] == 4'h0)
				vals[1][3:0] = 4'hf;
			host.ind_wr(PAGE_PGEN, 1'b1, 8'h01, vals[0]);
			for (int i = 1; i < 5; i++) begin
				host.xfer(1'b1, REG_IND_DATA, vals[i]);
			end
			`CHK(on, vals[0][0])
			`CHK(fx, vals[1][7])
			`CHK({bc, bt}, {vals[1][5:4], bars(vals[1][5:4])})
			`CHK(bs, vals[1][3:0])
			`CHK(vc, vals[2][7:6])
			`CHK(dt, vals[2][5:0])
			`CHK(ll, {vals[3], vals[4]})
			rd_chk(REG_IND_OFS, 8'h06);
			rd_chk(REG_IND_CTL, 8'h02);
			host.ind_rd(PAGE_PGEN, 1'b1, 8'h01);
			`CHK(host.rdata, vals[0])
			for (int i = 1; i < 5; i++) begin
				host.xfer(1'b0, REG_IND_DATA, 8'h00);
				`CHK(host.rdata, vals[i])
			end
		end
		// Page map edges, reserved pages and holes
		for (int i = 0; i < 10; i++) begin
			x = 8'($urandom) | 8'h01;
			host.ind_wr(pgs[i], 1'b1, ofs[i], x);
			rd_chk(REG_IND_OFS, ofs[i] + 8'h01);
			host.ind_rd(pgs[i], 1'b0, ofs[i]);
			`CHK(host.rdata, impl[i] ? x : 8'h00)
		end
		// Broadcast page lands in both channel sets
		x = 8'($urandom);
		host.ind_wr(PAGE_ALL, 1'b0, 8'h05, x);
		host.ind_rd(PAGE_CH0, 1'b0, 8'h05);
		`CHK(host.rdata, x)
		host.ind_rd(PAGE_CH1, 1'b0, 8'h05);
		`CHK(host.rdata, x)
		// Alias decoder: off, on, shared reach, off again
		host.tgt = 7'h31;
		host.xfer(1'b0, REG_IND_CTL, 8'h00);
		`CHK({host.done, host.claimed, host.rdata}, {2'b10, 8'h00})
		host.tgt = MAIN_T;
		host.xfer(1'b1, REG_ALIAS, 8'h63);
		rd_chk(REG_ALIAS, 8'h62);
		`CHK(host.port_one, 1'b0)
		host.tgt = 7'h31;
		host.xfer(1'b1, REG_IND_CTL, 8'h1c);
		`CHK({host.claimed, host.port_one}, 2'b11)
		rd_chk(REG_IND_CTL, 8'h1c);
		host.tgt = MAIN_T;
		host.xfer(1'b1, REG_ALIAS, 8'h00);
		host.tgt = 7'h31;
		host.xfer(1'b1, REG_IND_CTL, 8'h00);
		`CHK(host.claimed, 1'b0)
		host.tgt = MAIN_T;
		rd_chk(REG_IND_CTL, 8'h1c);
		// Mid-run reset restores the generator defaults
		@(posedge clock_i);
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		#1;
		`CHK({on, bt, bs, dt, ll}, {1'b0, 4'h8, 4'h3, 6'h24, 16'h0780})
		rd_chk(REG_IND_CTL, 8'h00);
		report_and_stop();
	end
endmodule : tb
